// ==== adc_scan_pkg.sv ====
`default_nettype none
package adc_scan_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_MASK_A  = 8'h04;
   localparam logic [7:0] OFS_MASK_B  = 8'h08;
   localparam logic [7:0] OFS_TRIGSEL = 8'h0C;
   localparam logic [7:0] OFS_SAMPLE  = 8'h10;
   localparam logic [7:0] OFS_EXTIN   = 8'h14;
   localparam logic [7:0] OFS_STATUS  = 8'h18;
   localparam logic [7:0] OFS_DUP     = 8'h1C;
   localparam logic [7:0] OFS_RESULT  = 8'h40;  // channel n at 40h + 4n
   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam int         CTRL_START_BIT = 0;
   localparam int         TRIG_B_LSB     = 8;
   localparam logic [7:0] SAMPLE_RESET   = 8'h14;
   localparam logic [3:0] TRIG_PIN_SEL   = 4'h0;
   // ------------------------------------------------------------
   // timing in cycles (peripheral and converter clock share CORE_CLK)
   // ------------------------------------------------------------
   localparam int         START_PCLK_SYNC  = 2;
   localparam int         START_PCLK_PIN   = 4;
   localparam int         START_CONVERTER_CLOCK      = 3;
   localparam int         CONV_HIGH_SPEED  = 23;
   localparam int         CONV_NORMAL      = 29;
   localparam int         END_CONVERTER_CLOCK        = 2;
   localparam logic [8:0] DLY_SYNC = 9'(START_PCLK_SYNC + START_CONVERTER_CLOCK - 1);
   localparam logic [8:0] DLY_PIN  = 9'(START_PCLK_PIN + START_CONVERTER_CLOCK - 1);
   localparam logic [8:0] CONV_HS  = 9'(CONV_HIGH_SPEED - 1);
   localparam logic [8:0] CONV_NS  = 9'(CONV_NORMAL - 1);
   localparam logic [8:0] END_DLY  = 9'(END_CONVERTER_CLOCK - 1);

   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00, MODE_GROUP = 2'b01, MODE_CONT = 2'b10
   } mode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_START = 3'b001, ST_SAMPLE = 3'b010,
      ST_CONVERT = 3'b011, ST_END = 3'b100
   } state_t;

   // control bits [13:1] of the control register
   typedef struct packed {
      logic       high_speed;
      logic [4:0] duplicate_channel_select;
      logic       duplicate_mode_enable;
      logic       group_b_irq_enable;
      logic       scan_end_irq_enable;
      logic       external_trigger_select;
      logic       trigger_enable;
      mode_t      mode;
   } ctrl_t;

   // drive towards the analog unit
   typedef struct packed {
      logic       sampling;
      logic       converting;
      logic [4:0] channel;
   } conv_ctrl_t;
endpackage
`default_nettype wire

// ==== adc_scan_sequencer.sv ====
`default_nettype none
module adc_scan_sequencer
   import adc_scan_pkg::*;
#(
   parameter int NUM_CH  = 8,
   parameter int NUM_TRG = 16
) (
   input  wire logic               CORE_CLK,
   input  wire logic               RESET,
   input  wire logic [7:0]         REG_ADDR,
   input  wire logic [31:0]        REG_WDATA,
   input  wire logic               REG_WR,
   input  wire logic               REG_RD,
   output logic      [31:0]        REG_RDATA,
   input  wire logic [NUM_TRG-1:0] SYNC_TRIGGERS,
   input  wire logic               ASYNC_TRIGGER_PIN,
   input  wire logic [11:0]        ANALOG_RESULT,
   output conv_ctrl_t              CONV_CTRL,
   output logic                    SCAN_END_IRQ,
   output logic                    GROUP_B_END_IRQ
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   ctrl_t             ctrl, next_ctrl;
   logic              start_flag, next_start_flag;
   logic [NUM_CH-1:0] mask_a, next_mask_a, mask_b, next_mask_b;
   logic [15:0]       trigsel, next_trigsel;
   logic [7:0]        sampling_states, next_sampling_states;
   logic [1:0]        extin, next_extin;
   state_t            state, next_state;
   logic [8:0]        cnt, next_cnt;
   logic [4:0]        chan, next_chan;
   logic              group_b, next_group_b, from_sw, next_from_sw;
   logic              dup_phase, next_dup_phase;
   logic              irq_a, next_irq_a, irq_b, next_irq_b;
   logic [31:0]       rdata, next_rdata;
   logic [11:0]       dup_result;
   logic [11:0]       result [NUM_CH];
   logic              pin_s1, pin_s2, pin_s3;
   logic              store_ch, store_dup;

   // first set bit of m at or above position from; bit 5 flags a find
   function automatic logic [5:0] first_from(input logic [NUM_CH-1:0] m, input logic [5:0] from);
      logic [5:0] r;
      r = 6'h00;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (m[i] && 6'(i) >= from) begin
            r = {1'b1, 5'(i)};
         end
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // trigger decode
   // ------------------------------------------------------------
   logic              pin_rise, trig_a, trig_b, sw_go, sw_stop, ctrl_wr;
   logic [NUM_CH-1:0] scan_mask;
   logic [5:0]        hit_first, hit_next;
   // only the pin goes through a synchroniser, sync triggers already share this clock
   assign pin_rise  = pin_s2 & ~pin_s3;
   assign ctrl_wr   = REG_WR && REG_ADDR == OFS_CTRL;
   assign sw_go     = ctrl_wr && REG_WDATA[CTRL_START_BIT];
   assign sw_stop   = ctrl_wr && !REG_WDATA[CTRL_START_BIT];
   assign trig_a    = ctrl.trigger_enable && (ctrl.external_trigger_select
                      ? (trigsel[3:0] == TRIG_PIN_SEL && pin_rise)
                      : SYNC_TRIGGERS[trigsel[3:0]]);
   assign trig_b    = ctrl.trigger_enable && ctrl.mode == MODE_GROUP
                      && SYNC_TRIGGERS[trigsel[TRIG_B_LSB +: 4]];
   // duplication narrows group A to the one named channel
   assign scan_mask = group_b ? mask_b : ctrl.duplicate_mode_enable
                      ? NUM_CH'(1) << ctrl.duplicate_channel_select : mask_a;
   assign hit_first = first_from(scan_mask, 6'h00);
   assign hit_next  = first_from(scan_mask, 6'({1'b0, chan} + 6'h01));

   // ------------------------------------------------------------
   // registers and sequencer, next values
   // ------------------------------------------------------------
   always_comb begin
      next_ctrl            = ctrl;
      next_start_flag      = start_flag;
      next_mask_a          = mask_a;
      next_mask_b          = mask_b;
      next_trigsel         = trigsel;
      next_sampling_states = sampling_states;
      next_extin           = extin;
      next_state           = state;
      next_cnt             = cnt;
      next_chan            = chan;
      next_group_b         = group_b;
      next_from_sw         = from_sw;
      next_dup_phase       = dup_phase;
      next_irq_a           = 1'b0;
      next_irq_b           = 1'b0;
      next_rdata           = 32'h0000_0000;
      store_ch             = 1'b0;
      store_dup            = 1'b0;
      if (REG_WR) begin
         case (REG_ADDR)
            OFS_CTRL:    next_ctrl = REG_WDATA[13:1];
            OFS_MASK_A:  next_mask_a = REG_WDATA[NUM_CH-1:0];
            OFS_MASK_B:  next_mask_b = REG_WDATA[NUM_CH-1:0];
            OFS_TRIGSEL: next_trigsel = REG_WDATA[15:0];
            OFS_SAMPLE:  next_sampling_states = REG_WDATA[7:0];
            OFS_EXTIN:   next_extin = REG_WDATA[1:0];
            default:     next_extin = extin;
         endcase
      end
      // sequencer steps
      case (state)
         ST_IDLE: begin
            // a new scan always begins at the lowest selected channel
            if (sw_go || trig_a || trig_b) begin
               next_start_flag = 1'b1;
               next_group_b    = !sw_go && !trig_a;
               next_from_sw    = sw_go;
               next_cnt        = (!sw_go && trig_a && ctrl.external_trigger_select) ? DLY_PIN : DLY_SYNC;
               next_state      = ST_START;
            end
         end
         ST_START: begin
            next_cnt = cnt - 9'h001;
            if (cnt == 9'h000) begin
               next_chan  = hit_first[4:0];
               next_cnt   = hit_first[5] ? 9'(sampling_states) : END_DLY;
               next_state = hit_first[5] ? ST_SAMPLE : ST_END;
            end
         end
         ST_SAMPLE: begin
            next_cnt = cnt - 9'h001;
            if (cnt == 9'h000) begin
               next_cnt   = ctrl.high_speed ? CONV_HS : CONV_NS;
               next_state = ST_CONVERT;
            end
         end
         ST_CONVERT: begin
            next_cnt = cnt - 9'h001;
            if (cnt == 9'h000) begin
               // second duplicated pass lands in the duplicate register
               store_dup = !group_b && ctrl.duplicate_mode_enable && !from_sw && dup_phase;
               store_ch  = !store_dup;
               if (hit_next[5]) begin
                  next_chan  = hit_next[4:0];
                  next_cnt   = 9'(sampling_states);
                  next_state = ST_SAMPLE;
               end else if (ctrl.mode == MODE_CONT) begin
                  // wrap straight into the next pass, no end delay
                  next_irq_a = ctrl.scan_end_irq_enable;
                  next_chan  = hit_first[4:0];
                  next_cnt   = 9'(sampling_states);
                  next_state = ST_SAMPLE;
               end else begin
                  next_cnt   = END_DLY;
                  next_state = ST_END;
               end
            end
         end
         ST_END: begin
            next_cnt = cnt - 9'h001;
            if (cnt == 9'h000) begin
               next_state      = ST_IDLE;
               next_start_flag = 1'b0;
               if (group_b) begin
                  next_irq_b = ctrl.group_b_irq_enable;
               end else if (ctrl.duplicate_mode_enable && !from_sw) begin
                  next_dup_phase = !dup_phase;
                  next_irq_a     = dup_phase && ctrl.scan_end_irq_enable;
               end else begin
                  next_irq_a = ctrl.scan_end_irq_enable;
               end
            end
         end
         default: next_state = ST_IDLE;
      endcase
      // writing 0 to the start flag aborts any scan; writing 1 while busy does nothing
      if (sw_stop) begin
         next_start_flag = 1'b0;
         next_state      = ST_IDLE;
      end
      if (REG_RD) begin
         if (REG_ADDR >= OFS_RESULT && REG_ADDR < 8'(OFS_RESULT + 4 * NUM_CH) && REG_ADDR[1:0] == 2'b00) begin
            next_rdata = {20'h00000, result[3'(REG_ADDR[7:2])]};
         end else begin
            case (REG_ADDR)
               OFS_CTRL:    next_rdata = {18'h0, ctrl, start_flag};
               OFS_MASK_A:  next_rdata = 32'(mask_a);
               OFS_MASK_B:  next_rdata = 32'(mask_b);
               OFS_TRIGSEL: next_rdata = {16'h0000, trigsel};
               OFS_SAMPLE:  next_rdata = {24'h000000, sampling_states};
               OFS_EXTIN:   next_rdata = {30'h0, extin};
               OFS_STATUS:  next_rdata = {16'h0000, 3'h0, chan, 3'h0, dup_phase, group_b, state};
               OFS_DUP:     next_rdata = {20'h00000, dup_result};
               default:     next_rdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // registers, clocked
   // ------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         ctrl            <= '0;
         start_flag      <= 1'b0;
         mask_a          <= '0;
         mask_b          <= '0;
         trigsel         <= 16'h0000;
         sampling_states <= SAMPLE_RESET;
         extin           <= 2'b00;
         state           <= ST_IDLE;
         cnt             <= 9'h000;
         chan            <= 5'h00;
         group_b         <= 1'b0;
         from_sw         <= 1'b0;
         dup_phase       <= 1'b0;
         irq_a           <= 1'b0;
         irq_b           <= 1'b0;
         rdata           <= 32'h0000_0000;
         pin_s1          <= 1'b0;
         pin_s2          <= 1'b0;
         pin_s3          <= 1'b0;
      end else begin
         ctrl            <= next_ctrl;
         start_flag      <= next_start_flag;
         mask_a          <= next_mask_a;
         mask_b          <= next_mask_b;
         trigsel         <= next_trigsel;
         sampling_states <= next_sampling_states;
         extin           <= next_extin;
         state           <= next_state;
         cnt             <= next_cnt;
         chan            <= next_chan;
         group_b         <= next_group_b;
         from_sw         <= next_from_sw;
         dup_phase       <= next_dup_phase;
         irq_a           <= next_irq_a;
         irq_b           <= next_irq_b;
         rdata           <= next_rdata;
         pin_s1          <= ASYNC_TRIGGER_PIN;
         pin_s2          <= pin_s1;
         pin_s3          <= pin_s2;
      end
   end

   // result storage, kept out of reset so it maps onto plain memory
   always_ff @(posedge CORE_CLK) begin
      if (store_ch) begin
         result[3'(chan)] <= ANALOG_RESULT;
      end
      if (store_dup) begin
         dup_result <= ANALOG_RESULT;
      end
   end

   assign REG_RDATA       = rdata;
   assign SCAN_END_IRQ    = irq_a;
   assign GROUP_B_END_IRQ = irq_b;
   assign CONV_CTRL       = '{sampling: state == ST_SAMPLE, converting: state == ST_CONVERT, channel: chan};

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   sequence s_enter_sample;
      state != ST_SAMPLE ##1 state == ST_SAMPLE;
   endsequence
   sequence s_enter_convert;
      state == ST_SAMPLE ##1 state == ST_CONVERT;
   endsequence
   property p_sample_len;
      s_enter_sample |-> cnt == 9'(sampling_states);
   endproperty
   a_sample_len: assert property (p_sample_len) else $error("sampling length wrong");
   property p_conv_len;
      s_enter_convert |-> cnt == (ctrl.high_speed ? 9'd22 : 9'd28);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
   property p_start_delay;
      (state == ST_IDLE && sw_go) |=> (state == ST_START && cnt == DLY_SYNC) ##5 (state != ST_START);
   endproperty
   a_start_delay: assert property (p_start_delay) else $error("start delay wrong");
   property p_end_delay;
      (state == ST_CONVERT && cnt == 0 && !hit_next[5] && ctrl.mode != MODE_CONT && !sw_stop)
         |=> state == ST_END ##1 state == ST_END ##1 state == ST_IDLE;
   endproperty
   a_end_delay: assert property (p_end_delay) else $error("end delay wrong");
   property p_busy_ignore;
      (state inside {ST_SAMPLE, ST_CONVERT} && !sw_stop) |=> state != ST_START;
   endproperty
   a_busy_ignore: assert property (p_busy_ignore) else $error("start taken while busy");
   property p_cont_wrap;
      (ctrl.mode == MODE_CONT && state == ST_CONVERT && cnt == 0 && !hit_next[5] && !sw_stop)
         |=> state == ST_SAMPLE && chan == $past(hit_first[4:0]) && start_flag;
   endproperty
   a_cont_wrap: assert property (p_cont_wrap) else $error("continuous pass gap");
   property p_stop;
      sw_stop |=> state == ST_IDLE && !start_flag;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not honoured");
   // the write must really land in the channel's own slot, not just be requested
   property p_store;
      (state == ST_CONVERT && cnt == 9'h000 && !store_dup) |=> result[3'($past(chan))] == $past(ANALOG_RESULT);
   endproperty
   a_store: assert property (p_store) else $error("result not stored");
   property p_irq_b_only;
      irq_b |-> !irq_a && $past(group_b) && $past(ctrl.group_b_irq_enable);
   endproperty
   a_irq_b_only: assert property (p_irq_b_only) else $error("group b irq wrong");
endmodule // adc_scan_sequencer
`default_nettype wire

// ==== adc_scan_sequencer_tb_top.sv ====
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module adc_scan_sequencer_tb_top
   import adc_scan_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk, reset, reg_wr, reg_rd, fire, pin_req, pin;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd_val;
   logic [15:0] sync_trig;
   logic [11:0] analog;
   logic [6:0]  level;
   logic [3:0]  fire_sel;
   conv_ctrl_t  conv;
   logic        scan_irq, gb_irq;
   int          bad_count, n_tests, cyc, s_run, c_run, n_irq, n_gb, n_conv, wr_t, last_irq, conv_end, a, b;
   int          samp_t[$], samp_q[$], conv_q[$], irq_t[$];
   logic [4:0]  chan_q[$];
   adc_scan_sequencer uut (.CORE_CLK(core_clk), .RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SYNC_TRIGGERS(sync_trig),
      .ASYNC_TRIGGER_PIN(pin), .ANALOG_RESULT(analog), .CONV_CTRL(conv), .SCAN_END_IRQ(scan_irq),
      .GROUP_B_END_IRQ(gb_irq));
   adc_trig_source src (.clk(core_clk), .reset(reset), .fire(fire), .fire_sel(fire_sel), .pin_req(pin_req),
      .level(level), .conv(conv), .sync_trig(sync_trig), .pin(pin), .analog(analog));
   // ----------------------------------------
   // clock and phase monitor
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // run lengths are pushed when a phase ends, so one pass needs no timestamps to check
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (conv.sampling === 1'b1) s_run <= s_run + 1;
      else if (s_run != 0) begin samp_q.push_back(s_run); s_run <= 0; end
      if (conv.sampling === 1'b1 && s_run == 0) begin chan_q.push_back(conv.channel); samp_t.push_back(cyc); end
      if (conv.converting === 1'b1) c_run <= c_run + 1;
      else if (c_run != 0) begin conv_q.push_back(c_run); c_run <= 0; n_conv++; conv_end = cyc; end
      if (scan_irq === 1'b1) begin irq_t.push_back(cyc); n_irq++; last_irq = cyc; end
      if (gb_irq === 1'b1) n_gb++;
      if (cyc == 30000) begin bad_count++; finish_test(); end // hang guard
   end
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge core_clk) begin reg_addr <= ad; reg_wdata <= d; reg_wr <= 1'b1; end
      @(posedge core_clk) reg_wr <= 1'b0;
      wr_t = cyc;
   endtask
   task automatic rd(input logic [7:0] ad);
      @(posedge core_clk) begin reg_addr <= ad; reg_rd <= 1'b1; end
      @(posedge core_clk) reg_rd <= 1'b0;
      @(posedge core_clk) rd_val = reg_rdata;
   endtask
   task automatic trig(input logic [3:0] s);
      @(posedge core_clk) begin fire <= 1'b1; fire_sel <= s; end
      @(posedge core_clk) fire <= 1'b0;
   endtask
   task automatic clr();
      samp_t.delete(); samp_q.delete(); conv_q.delete(); irq_t.delete(); chan_q.delete();
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      {reg_wr, reg_rd, fire, pin_req} = 4'h0;
      reg_addr = 8'h00; reg_wdata = 32'h0; fire_sel = 4'h0; level = 7'h2A;
      {bad_count, n_tests, cyc, s_run, c_run, n_irq, n_gb, n_conv} = '0;
      reset = 1'b1;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      rd(OFS_SAMPLE); `CHK(rd_val, 32'(SAMPLE_RESET))
      rd(8'hFC);      `CHK(rd_val, 32'h0)
      $display("test reset done");
      // continuous scan over channels 1, 3, 4 with short sampling, high speed
      wr(OFS_SAMPLE, 32'h3); wr(OFS_MASK_A, 32'h1A); wr(OFS_EXTIN, 32'h0); clr();
      wr(OFS_CTRL, 32'h2025);
      wait (n_irq >= 3);
      `CHK(samp_t[0] - wr_t, START_PCLK_SYNC + START_CONVERTER_CLOCK + 1)
      `CHK({chan_q[0], chan_q[1], chan_q[2], chan_q[3]}, {5'd1, 5'd3, 5'd4, 5'd1})
      `CHK(samp_q[0], 4)
      `CHK(conv_q[0], CONV_HIGH_SPEED)
      `CHK(irq_t[1] - irq_t[0], 3 * (4 + CONV_HIGH_SPEED))
      `CHK(irq_t[2] - irq_t[1], 3 * (4 + CONV_HIGH_SPEED))
      wr(OFS_CTRL, 32'h2024); repeat (4) @(posedge core_clk); a = n_irq; repeat (200) @(posedge core_clk);
      `CHK({conv.sampling, conv.converting}, 2'b00)
      `CHK(n_irq, a)
      rd(OFS_RESULT + 8'd12); `CHK(rd_val[11:0], {7'h2A, 5'd3})
      // restart with the scan-end interrupt disabled
      clr(); wr(OFS_CTRL, 32'h2005); repeat (300) @(posedge core_clk);
      `CHK(chan_q[0], 5'd1)
      `CHK(n_irq, a)
      wr(OFS_CTRL, 32'h2004); repeat (40) @(posedge core_clk);
      $display("test continuous done");
      // group scan, normal speed: B on trigger 5, A on trigger 2
      wr(OFS_MASK_A, 32'h01); wr(OFS_MASK_B, 32'h80); wr(OFS_TRIGSEL, 32'h0502); clr();
      wr(OFS_CTRL, 32'h006A); a = n_irq;
      trig(4'd5); wait (n_gb == 1);
      `CHK(n_irq, a)
      `CHK(conv_q[0], CONV_NORMAL)
      trig(4'd2); repeat (10) @(posedge core_clk); trig(4'd2);
      wait (n_irq == a + 1); repeat (300) @(posedge core_clk);
      `CHK({n_irq, n_gb}, {a + 1, 32'd1})
      `CHK({chan_q[0], chan_q[1]}, {5'd7, 5'd0})
      $display("test group done");
      // duplication on channel 2 driven by trigger 2
      wr(OFS_CTRL, 32'h02EA); level <= 7'h11; a = n_conv; b = n_irq;
      trig(4'd2); wait (n_conv == a + 1); repeat (10) @(posedge core_clk);
      `CHK(n_irq, b)
      rd(OFS_RESULT + 8'd8); `CHK(rd_val[11:0], {7'h11, 5'd2})
      a = n_irq; level <= 7'h22; trig(4'd2); wait (n_irq == a + 1);
      rd(OFS_DUP); `CHK(rd_val[11:0], {7'h22, 5'd2})
      // software starts stay out of group mode, so single mode with duplication kept
      level <= 7'h33; wr(OFS_CTRL, 32'h02E9); wait (n_irq == a + 2); repeat (5) @(posedge core_clk);
      level <= 7'h44; wr(OFS_CTRL, 32'h02E9); wait (n_irq == a + 3);
      rd(OFS_DUP); `CHK(rd_val[11:0], {7'h22, 5'd2})
      $display("test duplicate done");
      // pin start in single mode
      wr(OFS_CTRL, 32'h0); wr(OFS_TRIGSEL, 32'h0); wr(OFS_MASK_A, 32'h02); wr(OFS_CTRL, 32'h0038);
      clr(); a = n_irq;
      @(posedge core_clk) pin_req <= 1'b1;
      wr_t = cyc;
      wait (n_irq == a + 1); pin_req <= 1'b0;
      // synchroniser phase leaves three cycles of slack at the start, one at the end
      `CHK((samp_t[0] - wr_t) inside {[START_PCLK_PIN + START_CONVERTER_CLOCK + 3 : START_PCLK_PIN + START_CONVERTER_CLOCK + 6]}, 1'b1)
      `CHK((last_irq - conv_end) inside {[END_CONVERTER_CLOCK : END_CONVERTER_CLOCK + 1]}, 1'b1)
      `CHK(chan_q[0], 5'd1)
      $display("test pin done");
      finish_test();
   end
endmodule // adc_scan_sequencer_tb_top
`default_nettype wire

// ==== adc_trig_source.sv ====
`default_nettype none
module adc_trig_source
   import adc_scan_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        fire,
   input  wire logic [3:0]  fire_sel,
   input  wire logic        pin_req,
   input  wire logic [6:0]  level,
   input  wire conv_ctrl_t  conv,
   output logic      [15:0] sync_trig,
   output logic             pin,
   output logic      [11:0] analog
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // trigger sources
   // ----------------------------------------
   // one-cycle pulse on the selected line only, as a timer compare would give
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync_trig <= 16'h0000;
         pin       <= 1'b0;
      end else begin
         sync_trig <= fire ? (16'h0001 << fire_sel) : 16'h0000;
         pin       <= pin_req;
      end
   end
   // analog value carries the channel; inverted outside conversion so a stale sample shows
   always_comb begin
      analog = conv.converting ? {level, conv.channel} : ~{level, conv.channel};
   end
endmodule // adc_trig_source
`default_nettype wire
